// file: fdc_ctl_pkg.sv
package fdc_ctl_pkg;
  // apb register byte offsets
  localparam logic [7:0] ctl_cmd_off    = 8'h00;
  localparam logic [7:0] ctl_cfg_off    = 8'h04;
  localparam logic [7:0] ctl_status_off = 8'h08;
  localparam logic [7:0] ctl_result_off = 8'h0c;
  localparam logic [7:0] ctl_track_off  = 8'h10;
  localparam logic [7:0] ctl_id_off     = 8'h14;

  // command codes written to the command register
  localparam logic [2:0] cmd_read_id     = 3'h1;
  localparam logic [2:0] cmd_recal       = 3'h2;
  localparam logic [2:0] cmd_seek        = 3'h3;
  localparam logic [2:0] cmd_sense_int   = 3'h4;
  localparam logic [2:0] cmd_sense_drive = 3'h5;
  localparam logic [2:0] cmd_xfer_done   = 3'h6;

  // status register 0 and 1 fields
  localparam int st0_term_lsb   = 6;
  localparam int st0_pos_done   = 5;
  localparam int st0_trk0_fault = 4;
  localparam int st0_side_bit   = 2;
  localparam logic [1:0] term_normal   = 2'b00;
  localparam logic [1:0] term_abnormal = 2'b01;
  localparam logic [1:0] term_ready_chg = 2'b11;
  localparam int st1_no_id = 0;

  // recalibrate step budget
  localparam logic [6:0] recal_max_steps = 7'd79;

  // step interval: (16 - step_interval field) x unit, unit scaled by data rate
  localparam int step_unit_us_250k = 2;
  localparam int clk_mhz           = 200;
  localparam int step_unit_cycles  = step_unit_us_250k * clk_mhz;
  localparam int step_pulse_ns     = 100;
  localparam int clk_period_ns     = 5;
  localparam logic [7:0] step_pulse_cycles = 8'(step_pulse_ns / clk_period_ns);

  typedef enum logic [2:0] {
    st_idle, st_pos_step, st_pos_wait, st_readid, st_result
  } seq_state_t;
endpackage

// file: step_timer.sv
`timescale 1ns/1ps
module step_timer
  import fdc_ctl_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        start,
  input  wire logic [3:0]  step_interval,
  input  wire logic [1:0]  rate_sel,
  output logic             step_pulse,
  output logic             done
);
  // total interval = (16 - field) units, unit halves per rate step up
  logic [23:0] cnt_q;
  logic [23:0] cnt_d;
  logic [23:0] load_val;
  assign load_val = 24'((5'd16 - {1'b0, step_interval}) * step_unit_cycles) >> rate_sel;
  assign cnt_d    = start ? load_val : (cnt_q != 24'h0 ? cnt_q - 24'h1 : 24'h0);
  // pulse occupies the first cycles of the interval
  assign step_pulse = (cnt_q != 24'h0) && ((load_val - cnt_q) < 24'(step_pulse_cycles));
  assign done       = (cnt_q == 24'h1);

  always_ff @(posedge sys_clk) begin
    if (!rstn) cnt_q <= 24'h0;
    else       cnt_q <= cnt_d;
  end
endmodule

// file: fdc_ctl_seq.sv
`timescale 1ns/1ps
// Behaviour
// - control commands move no data; only read id, recal, seek interrupt
// - read id captures first id; no mark by second index sets code 01, no-id
// - recalibrate clears track count, steps with direction 0 while track zero low
// - track zero high during recalibrate sets positioning done and ends
// - still low after 79 steps sets positioning done and track zero fault
// - seek and recalibrate busy only in command phase
// - seek with current below target steps in, direction 1
// - seek with current above target steps out, direction 0
// - seek spaces steps by interval, compares after each, done on equality
// - interrupt asserts on result phase entry of data commands and read id
// - interrupt asserts when seek or recalibrate ends
// - non-dma mode interrupts whenever a data byte is needed
// - sense interrupt status clears interrupt, reports code and done flag
// - side bit of status 0 after positioning reads 0
// - without sense interrupt status the drive stays marked busy
// - sense drive status skips execution, returns status register 3
// - step interval sets spacing between steps, scaled by data rate
// - dma bypass 1 selects non-dma mode with request bit and interrupt
module fdc_ctl_seq
  import fdc_ctl_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        index_pulse_input,
  input  wire logic        track_zero_input,
  input  wire logic        id_found,
  input  wire logic [31:0] id_field,
  input  wire logic        data_byte_req,
  input  wire logic [7:0]  drive_status,
  output logic             step_out,
  output logic             direction_out,
  output logic             controller_irq_output,
  output logic             request_for_master_bit,
  output logic             busy_out
);
  seq_state_t  state_q, state_d;
  logic [7:0]  current_track_count_q;
  logic [7:0]  target_track_q;
  logic [3:0]  step_interval_q;
  logic [1:0]  rate_sel_q;
  logic        dma_bypass_select_q;
  logic        irq_q;
  logic        pending_q;
  logic        is_recal_q;
  logic        dir_q;
  logic [6:0]  steps_q;
  logic [1:0]  index_seen_q;
  logic        index_prev_q;
  logic [7:0]  st0_q;
  logic [7:0]  st1_q;
  logic [7:0]  result_q;
  logic [31:0] id_q;
  logic        drive_busy_q;
  logic [31:0] prdata_q;

  // bus decode
  wire wr_en      = psel && penable && pwrite;
  wire rd_en      = psel && penable && !pwrite;
  wire wr_cmd     = wr_en && (paddr == ctl_cmd_off);
  wire wr_cfg     = wr_en && (paddr == ctl_cfg_off);
  wire [2:0] cmd  = pwdata[2:0];
  wire addr_ok    = (paddr == ctl_cmd_off) || (paddr == ctl_cfg_off) || (paddr == ctl_status_off) ||
                    (paddr == ctl_result_off) || (paddr == ctl_track_off) || (paddr == ctl_id_off);
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !addr_ok;
  assign prdata   = prdata_q;

  // command acceptance only while sequencer idle
  wire accept     = wr_cmd && (state_q == st_idle);
  wire go_recal   = accept && (cmd == cmd_recal);
  wire go_seek    = accept && (cmd == cmd_seek);
  wire go_readid  = accept && (cmd == cmd_read_id);
  wire go_sense   = accept && (cmd == cmd_sense_int);
  wire go_sdrive  = accept && (cmd == cmd_sense_drive);
  wire go_xfer    = accept && (cmd == cmd_xfer_done);
  wire index_rise = index_pulse_input && !index_prev_q;

  // step timing
  logic timer_start;
  logic timer_pulse;
  logic timer_done;
  step_timer u_step_timer (
    .sys_clk       (sys_clk),
    .rstn          (rstn),
    .start         (timer_start),
    .step_interval (step_interval_q),
    .rate_sel      (rate_sel_q),
    .step_pulse    (timer_pulse),
    .done          (timer_done)
  );

  // positioning decisions
  wire at_target  = (current_track_count_q == target_track_q);
  wire recal_end  = is_recal_q && (track_zero_input || steps_q >= recal_max_steps);
  wire seek_end   = !is_recal_q && at_target;
  wire pos_finish = (state_q == st_pos_wait) && timer_done && (recal_end || seek_end);
  wire pos_check0 = (state_q == st_pos_step) && (recal_end || seek_end);
  wire pos_end    = pos_finish || pos_check0;
  wire rid_fail   = (state_q == st_readid) && !id_found && index_rise && (index_seen_q == 2'd1);
  wire rid_ok     = (state_q == st_readid) && id_found;
  wire step_dir   = is_recal_q ? 1'b0 : (current_track_count_q < target_track_q);

  assign timer_start = (state_q == st_pos_step) && !pos_check0;

  // sequencer next state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      st_idle:     if (go_recal || go_seek) state_d = st_pos_step;
                   else if (go_readid) state_d = st_readid;
                   else if (go_sdrive) state_d = st_result;
      st_pos_step: state_d = pos_check0 ? st_idle : st_pos_wait;
      st_pos_wait: if (timer_done) state_d = pos_finish ? st_idle : st_pos_step;
      st_readid:   if (rid_ok || rid_fail) state_d = st_result;
      st_result:   state_d = st_idle;
    endcase
  end

  // state and positioning registers
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state_q               <= st_idle;
      current_track_count_q <= 8'h00;
      target_track_q        <= 8'h00;
      is_recal_q            <= 1'b0;
      dir_q                 <= 1'b0;
      steps_q               <= 7'd0;
      index_prev_q          <= 1'b0;
    end else begin
      state_q      <= state_d;
      index_prev_q <= index_pulse_input;
      if (go_recal) begin
        current_track_count_q <= 8'h00;
        is_recal_q            <= 1'b1;
        steps_q               <= 7'd0;
        dir_q                 <= 1'b0;
      end else if (go_seek) begin
        // direction settles a cycle before the first step, never moves under a pulse
        target_track_q <= pwdata[15:8];
        is_recal_q     <= 1'b0;
        steps_q        <= 7'd0;
        dir_q          <= (current_track_count_q < pwdata[15:8]);
      end else if (timer_start) begin
        dir_q   <= step_dir;
        steps_q <= steps_q + 7'd1;
        if (!is_recal_q)
          current_track_count_q <= step_dir ? current_track_count_q + 8'h01 : current_track_count_q - 8'h01;
      end
    end
  end

  // configuration registers
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      step_interval_q     <= 4'h0;
      rate_sel_q          <= 2'h0;
      dma_bypass_select_q <= 1'b0;
    end else if (wr_cfg) begin
      step_interval_q     <= pwdata[3:0];
      rate_sel_q          <= pwdata[5:4];
      dma_bypass_select_q <= pwdata[8];
    end
  end

  // read id index counting and capture
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      index_seen_q <= 2'd0;
      id_q         <= 32'h0;
    end else begin
      if (go_readid) index_seen_q <= 2'd0;
      else if ((state_q == st_readid) && index_rise && index_seen_q != 2'd2) index_seen_q <= index_seen_q + 2'd1;
      if (rid_ok) id_q <= id_field;
    end
  end

  // status 0/1 and result byte
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      st0_q    <= 8'h00;
      st1_q    <= 8'h00;
      result_q <= 8'h00;
    end else begin
      if (pos_end) begin
        st0_q <= 8'h00;
        st0_q[st0_term_lsb +: 2] <= term_normal;
        st0_q[st0_pos_done]      <= 1'b1;
        st0_q[st0_trk0_fault]    <= is_recal_q && !track_zero_input;
        st0_q[st0_side_bit]      <= 1'b0;
      end else if (rid_fail) begin
        st0_q <= 8'h00;
        st0_q[st0_term_lsb +: 2] <= term_abnormal;
        st1_q[st1_no_id]         <= 1'b1;
      end else if (rid_ok) begin
        st0_q <= 8'h00;
        st1_q <= 8'h00;
      end
      if (go_sense) result_q <= pending_q ? st0_q : {term_ready_chg, 6'h00};
      else if (go_sdrive) result_q <= drive_status;
    end
  end

  // interrupt, pending positioning result and drive busy
  wire irq_set = pos_end || (state_q == st_readid && state_d == st_result) || go_xfer ||
                 (dma_bypass_select_q && data_byte_req);
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      irq_q        <= 1'b0;
      pending_q    <= 1'b0;
      drive_busy_q <= 1'b0;
    end else begin
      if (irq_set) irq_q <= 1'b1; // set wins over clear
      else if (go_sense) irq_q <= 1'b0;
      if (pos_end) pending_q <= 1'b1;
      else if (go_sense) pending_q <= 1'b0;
      if (go_recal || go_seek) drive_busy_q <= 1'b1;
      else if (go_sense && !(state_q != st_idle)) drive_busy_q <= 1'b0;
    end
  end

  // read mux, registered
  always_ff @(posedge sys_clk) begin
    if (!rstn) prdata_q <= 32'h0;
    else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        ctl_cfg_off:    prdata_q <= {23'h0, dma_bypass_select_q, 2'h0, rate_sel_q, step_interval_q};
        ctl_status_off: prdata_q <= {16'h0, st1_q, 3'h0, drive_busy_q, pending_q, busy_out,
                                     request_for_master_bit, irq_q};
        ctl_result_off: prdata_q <= {24'h0, result_q};
        ctl_track_off:  prdata_q <= {16'h0, target_track_q, current_track_count_q};
        ctl_id_off:     prdata_q <= id_q;
        default:        prdata_q <= 32'h0;
      endcase
    end
  end

  // busy only for read id execution and the result phase
  assign busy_out               = (state_q == st_readid) || (state_q == st_result);
  assign request_for_master_bit = !busy_out || (dma_bypass_select_q && data_byte_req);
  assign controller_irq_output  = irq_q;
  assign step_out               = timer_pulse;
  assign direction_out          = dir_q;
  wire unused_rd = rd_en;
endmodule

// file: fdc_ctl_seq_props.sv
`timescale 1ns/1ps
module fdc_ctl_seq_props
  import fdc_ctl_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rstn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        step_out,
  input wire logic        direction_out,
  input wire logic        controller_irq_output,
  input wire logic        busy_out
);
  // command writes taken only when the sequencer is quiet
  wire acc = psel && penable;
  wire cmd_wr = acc && pwrite && paddr == ctl_cmd_off && !busy_out && !step_out;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  a_ready_always: assert property (psel |-> pready) else $error("pready low in transfer");
  a_unmapped_err: assert property (acc && paddr > ctl_id_off |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_step_width: assert property ($rose(step_out) |-> step_out[*8]) else $error("step too short");
  a_step_gap: assert property ($fell(step_out) |-> !step_out[*8]) else $error("steps too close");
  a_dir_steady: assert property (step_out |-> $stable(direction_out)) else $error("dir moved");
  a_idle_stepping: assert property (step_out |-> !busy_out) else $error("busy while stepping");
  a_sense_clears: assert property (cmd_wr && pwdata[2:0] == cmd_sense_int |-> ##[1:2] !controller_irq_output)
    else $error("irq not cleared");
  a_quiet_drive: assert property (cmd_wr && pwdata[2:0] == cmd_sense_drive && !controller_irq_output
    |=> !controller_irq_output[*4]) else $error("irq from drive status");
  c_step_in: cover property ($rose(step_out) && direction_out);
  c_step_out: cover property ($rose(step_out) && !direction_out);
  c_irq: cover property ($rose(controller_irq_output));
endmodule

// file: drive_model.sv
`timescale 1ns/1ps
module drive_model (
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  input  wire logic       step_out,
  input  wire logic       direction_out,
  input  wire logic       load,
  input  wire logic [7:0] load_pos,
  input  wire logic       id_en,
  output logic            track_zero_input,
  output logic            index_pulse_input,
  output logic            id_found,
  output logic [7:0]      head
);
  logic       step_q;
  logic [7:0] idx_q;
  // head moves on each step edge; it cannot go below the stop at zero
  always_ff @(posedge sys_clk) begin
    step_q <= step_out;
    idx_q <= (!rstn || idx_q == 8'hc7) ? 8'h00 : idx_q + 8'h01;
    if (!rstn) head <= 8'h07;
    else if (load) head <= load_pos;
    else if (step_out && !step_q) head <= direction_out ? head + 8'h01 : head - {7'h0, head != 8'h00};
  end
  // short rotation keeps the two-index wait of a missing mark brief
  assign track_zero_input = (head == 8'h00);
  assign index_pulse_input = (idx_q < 8'h02);
  assign id_found = id_en && idx_q == 8'h64;
endmodule

// file: floppy_control_command_seq_bench.sv
`timescale 1ns/1ps
module floppy_control_command_seq_bench
  import fdc_ctl_pkg::*;
;
  logic        sys_clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, data_byte_req = 0, load = 0, id_en = 0;
  logic [7:0]  paddr = 0, drive_status = 0, load_pos = 0, head, tgt;
  logic [31:0] pwdata = 0, id_field = 0, prdata, rd;
  logic        pready, pslverr, index_pulse_input, track_zero_input, id_found;
  logic        step_out, direction_out, controller_irq_output, request_for_master_bit, busy_out;
  int          n_fail = 0, total_checks = 0, cyc = 0, seed = 3;
  fdc_ctl_seq fdc_ctl_seq_inst (.sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .index_pulse_input(index_pulse_input), .track_zero_input(track_zero_input), .id_found(id_found),
    .id_field(id_field), .data_byte_req(data_byte_req), .drive_status(drive_status), .step_out(step_out),
    .direction_out(direction_out), .controller_irq_output(controller_irq_output),
    .request_for_master_bit(request_for_master_bit), .busy_out(busy_out));
  drive_model drive_model_inst (.sys_clk(sys_clk), .rstn(rstn), .step_out(step_out), .direction_out(direction_out),
    .load(load), .load_pos(load_pos), .id_en(id_en), .track_zero_input(track_zero_input),
    .index_pulse_input(index_pulse_input), .id_found(id_found), .head(head));
  initial forever #2.5 sys_clk = ~sys_clk;
  // one apb transfer; read data taken at the edge that sees pready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge sys_clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    k = 0;
    @(posedge sys_clk);
    while (pready !== 1'b1 && k < 100) begin
      @(posedge sys_clk);
      k++;
    end
    if (k >= 100) begin
      n_fail++;
      $display("FAIL t=%0t apb answer missing", $time);
    end
    rd = prdata;
    psel <= 0;
    penable <= 0;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
    total_checks++;
    if ((got & m) !== (exp & m)) begin
      n_fail++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // poll status until the interrupt bit shows, bounded
  task wait_irq;
    int k;
    k = 0;
    apb(0, ctl_status_off, 0);
    while (rd[0] !== 1'b1 && k < 3000) begin
      apb(0, ctl_status_off, 0);
      k++;
    end
    chk(rd, 32'h1, 32'h1);
  endtask
  task sense(input logic [31:0] m, input logic [31:0] e);
    apb(1, ctl_cmd_off, {29'h0, cmd_sense_int});
    apb(0, ctl_result_off, 0);
    chk(rd, e, m);
    apb(0, ctl_status_off, 0);
    chk(rd, 32'h0, 32'h1);
  endtask
  task recal(input logic [7:0] start, input logic [31:0] e);
    @(posedge sys_clk) load <= 1;
    load_pos <= start;
    @(posedge sys_clk) load <= 0;
    apb(1, ctl_cmd_off, {29'h0, cmd_recal});
    apb(0, ctl_status_off, 0);
    chk(rd, 32'h10, 32'h14);
    wait_irq;
    sense(32'h34, e);
  endtask
  task print_verdict;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // hang guard, well above the longest recalibrate
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail++;
      print_verdict;
    end
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    rstn <= 1;
    apb(1, ctl_cfg_off, 32'h13f);
    recal(8'd5, 32'h20);
    apb(0, ctl_track_off, 0);
    chk(rd, 32'h0, 32'hff);
    for (int i = 0; i < 4; i++) begin
      tgt = (i == 0) ? 8'h00 : 8'($random(seed) & 32'h1f);
      if (tgt == head) tgt = tgt ^ 8'h01;
      apb(1, ctl_cmd_off, {16'h0, tgt, 5'h0, cmd_seek});
      wait_irq;
      sense(32'h24, 32'h20);
      apb(0, ctl_track_off, 0);
      chk(rd, {24'h0, tgt}, 32'hff);
      chk({24'h0, head}, {24'h0, tgt}, 32'hff);
    end
    recal(8'd100, 32'h30);
    chk({24'h0, head}, 32'd21, 32'hff);
    recal(head, 32'h20);
    apb(1, ctl_cmd_off, {16'h0, 8'h03, 5'h0, cmd_seek});
    wait_irq;
    sense(32'h24, 32'h20);
    // id carries the typical 3.5-inch mfm layout: size code 2, 09 sectors
    id_field <= {8'($random(seed)), 8'h00, 8'h09, 8'h02};
    id_en <= 1;
    apb(1, ctl_cmd_off, {29'h0, cmd_read_id});
    wait_irq;
    apb(0, ctl_id_off, 0);
    chk(rd, id_field, 32'hffffffff);
    sense(32'h0, 32'h0);
    id_en <= 0;
    apb(1, ctl_cmd_off, {29'h0, cmd_read_id});
    wait_irq;
    chk(rd, 32'h100, 32'h100);
    sense(32'h0, 32'h0);
    drive_status <= 8'($random(seed));
    apb(1, ctl_cmd_off, {29'h0, cmd_sense_drive});
    apb(0, ctl_result_off, 0);
    chk(rd, {24'h0, drive_status}, 32'hff);
    apb(0, ctl_status_off, 0);
    chk(rd, 32'h0, 32'h1);
    apb(1, ctl_cmd_off, {29'h0, cmd_xfer_done});
    apb(0, ctl_status_off, 0);
    chk(rd, 32'h1, 32'h1);
    sense(32'h0, 32'h0);
    // non-dma byte request raises the interrupt and the request bit
    data_byte_req <= 1;
    apb(0, ctl_status_off, 0);
    chk(rd, 32'h3, 32'h3);
    data_byte_req <= 0;
    sense(32'h0, 32'h0);
    apb(0, 8'h40, 0);
    chk(rd, 32'h0, 32'hffffffff);
    print_verdict;
  end
endmodule
bind fdc_ctl_seq fdc_ctl_seq_props props_inst (.sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .step_out(step_out), .direction_out(direction_out), .controller_irq_output(controller_irq_output),
  .busy_out(busy_out));
